// [core/eepc_ctrl.sv]
// EEPROM control register, row programming sequencer and cell array.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module eepc_ctrl #(
    parameter int PROG_CYCLES = eepc_pkg::PROG_CYCLES,
    parameter int WORDS = 64
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic ee_sel_in,
    input wire logic stop_in,
    output logic [7:0] rdata_out,
    output logic busy_out,
    output logic standby_out,
    output logic irq_out
);
    initial begin
        if (PROG_CYCLES < 1 || PROG_CYCLES > 65535) $error("Bad programming length.");
        if (WORDS != 64) $error("Array must hold 64 bytes.");
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic standby_q, go_q, arm_q, enable_q;
    logic [15:0] cnt_q;
    logic [7:0] mem_q [WORDS];
    logic [7:0] rdata_q;
    logic [1:0] irq_stat_q, irq_mask_q;
    logic [4:0] row_q;
    eepc_pkg::eepc_state_t state_q;
    logic busy;
    logic ctrl_wr, ctrl_rd, ee_wr, ee_rd, ee_ok, byte_start, row_start, arm_set;
    logic ev_done, ev_abort;
    logic [63:0] row_data;
    logic [7:0] row_loaded;

    assign busy = (state_q != eepc_pkg::ST_IDLE);
    assign ctrl_wr = wr_in && addr_in == eepc_pkg::CTRL_ADDR;
    assign ctrl_rd = rd_in && addr_in == eepc_pkg::CTRL_ADDR;
    assign ee_wr = wr_in && ee_sel_in && addr_in <= eepc_pkg::EE_TOP_ADDR;
    assign ee_rd = rd_in && ee_sel_in && addr_in <= eepc_pkg::EE_TOP_ADDR;
    // Standby or a pending stop makes the array deaf.
    assign ee_ok = !standby_q && !stop_in && !busy;
    assign byte_start = ee_wr && ee_ok && enable_q && !arm_q;
    assign arm_set = ctrl_wr && !busy && wdata_in[eepc_pkg::ARM_BIT] && !arm_q;
    assign row_start = ctrl_wr && !busy && wdata_in[eepc_pkg::GO_BIT]
                     && enable_q && arm_q && !standby_q && !stop_in;
    assign ev_done = busy && cnt_q == 16'h0001;
    assign ev_abort = (ee_wr || ee_rd) && busy;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            standby_q <= 1'b0;
            go_q <= 1'b0;
            arm_q <= 1'b0;
            enable_q <= 1'b0;
        end else begin
            if (busy) begin
                // Writes while busy are dropped; go and arm fall as the row ends.
                if (ev_done && state_q == eepc_pkg::ST_ROW) begin
                    go_q <= 1'b0;
                    arm_q <= 1'b0;
                end
            end else if (ctrl_wr) begin
                standby_q <= wdata_in[eepc_pkg::STANDBY_BIT];
                enable_q <= wdata_in[eepc_pkg::ENABLE_BIT];
                arm_q <= wdata_in[eepc_pkg::ARM_BIT];
                go_q <= row_start;
            end
            // Stop comes last so it beats a control write in the same cycle, while a
            // row that is finishing still drops its start and arm bits.
            if (stop_in) begin
                standby_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Programming sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= eepc_pkg::ST_IDLE;
            cnt_q <= 16'h0000;
        end else begin
            // A cycle starts only from idle, so an access while busy cannot restart the count.
            case (state_q)
                eepc_pkg::ST_IDLE: begin
                    if (row_start) begin
                        state_q <= eepc_pkg::ST_ROW;
                        cnt_q <= 16'(PROG_CYCLES);
                    end else if (byte_start) begin
                        state_q <= eepc_pkg::ST_BYTE;
                        cnt_q <= 16'(PROG_CYCLES);
                    end
                end
                eepc_pkg::ST_BYTE, eepc_pkg::ST_ROW: begin
                    cnt_q <= cnt_q - 16'h0001;
                    if (ev_done) begin
                        state_q <= eepc_pkg::ST_IDLE;
                    end
                end
                default: state_q <= eepc_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Row latch and cell array
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            row_q <= 5'h00;
        end else if (arm_q && !go_q && ee_wr && ee_ok) begin
            row_q <= addr_in[7:3];
        end
    end

    // Arming clears the latches, and so does a control write that drops arm.
    eepc_row_latch #(
        .BYTES(8)
    ) u_row (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .clear_in(arm_set || (ctrl_wr && !busy && !wdata_in[eepc_pkg::ARM_BIT])),
        .load_in(arm_q && !go_q && ee_wr && ee_ok),
        .sel_in(addr_in[2:0]),
        .data_in(wdata_in),
        .data_out(row_data),
        .loaded_out(row_loaded)
    );

    // Cells change only when a cycle ends, so an aborted access never corrupts them.
    logic [7:0] byte_addr_q, byte_data_q;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            byte_addr_q <= 8'h00;
            byte_data_q <= 8'h00;
        end else if (byte_start) begin
            byte_addr_q <= addr_in;
            byte_data_q <= wdata_in;
        end
    end

    // The cells have no reset because they model storage that keeps its contents.
    // Cells never programmed therefore read unknown.
    always_ff @(posedge sys_clk_in) begin
        if (ev_done && state_q == eepc_pkg::ST_BYTE) begin
            mem_q[byte_addr_q[5:0]] <= byte_data_q;
        end else if (ev_done && state_q == eepc_pkg::ST_ROW) begin
            for (int i = 0; i < 8; i++) begin
                if (row_loaded[i]) begin
                    mem_q[{row_q[2:0], 3'(i)}] <= row_data[i*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts and read data
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_stat_q <= 2'h0;
            irq_mask_q <= 2'h0;
        end else begin
            // Set wins over a clear landing in the same cycle.
            irq_stat_q <= (irq_stat_q & ~((wr_in && addr_in == eepc_pkg::IRQ_STATUS_ADDR)
                          ? wdata_in[1:0] : 2'h0)) | {ev_abort, ev_done};
            if (wr_in && addr_in == eepc_pkg::IRQ_MASK_ADDR) begin
                irq_mask_q <= wdata_in[1:0];
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_q <= 8'h00;
        end else if (ctrl_rd) begin
            rdata_q <= {6'h00, busy, 1'b0};
        end else if (rd_in && addr_in == eepc_pkg::IRQ_STATUS_ADDR) begin
            rdata_q <= {6'h00, irq_stat_q};
        end else if (rd_in && addr_in == eepc_pkg::IRQ_MASK_ADDR) begin
            rdata_q <= {6'h00, irq_mask_q};
        end else if (ee_rd && ee_ok && !arm_q) begin
            rdata_q <= mem_q[addr_in[5:0]];
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // Read data stand one cycle and are zero otherwise, so a stale value never looks fresh.
    assign rdata_out = rdata_q;
    assign busy_out = busy;
    assign standby_out = standby_q;
    assign irq_out = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // Counts the cycles of the current busy stretch, so the length check need not
    // unroll a repetition as long as the programming time.
    logic [15:0] busy_run_q;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_run_q <= 16'h0000;
        end else if (busy) begin
            busy_run_q <= busy_run_q + 16'h0001;
        end else begin
            busy_run_q <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_busy_length: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        $fell(busy) |-> busy_run_q == 16'(PROG_CYCLES))
        else $error("Busy length wrong.");
    a_busy_cap: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        busy |-> busy_run_q < 16'(PROG_CYCLES))
        else $error("Busy lasted too long.");
    a_go_clears: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (state_q == eepc_pkg::ST_ROW && ev_done) |=> !go_q && !arm_q)
        else $error("Start or arm not cleared.");
    a_no_enable_write: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (!busy && ee_wr && !enable_q) |=> !busy) else $error("Write started without enable.");
    a_ctrl_read_busy: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        ctrl_rd |=> rdata_out == {6'h00, $past(busy), 1'b0}) else $error("Bad control read.");
    a_stop_standby: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        stop_in |=> standby_out) else $error("Stop did not force standby.");
    a_go_needs_arm: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        $rose(go_q) |-> $past(arm_q) && $past(enable_q)) else $error("Start without arm.");
    a_busy_write_drop: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (busy && ctrl_wr && !ev_done && !stop_in) |=> $stable(enable_q) && $stable(standby_q))
        else $error("Control changed while busy.");
    a_standby_blocks: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (standby_q && !busy && !row_start) |=> !busy) else $error("Cycle began in standby.");
    a_done_flag: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        ev_done |=> irq_stat_q[eepc_pkg::IRQ_DONE_BIT])
        else $error("Done flag not set.");
    a_abort_flag: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        ev_abort |=> irq_stat_q[eepc_pkg::IRQ_ABORT_BIT])
        else $error("Abort flag not set.");
    a_busy_read_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (busy && ee_rd) |=> rdata_out == 8'h00)
        else $error("Array read served while busy.");
    a_standby_read: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (standby_q && ee_rd) |=> rdata_out == 8'h00)
        else $error("Array read served in standby.");
    a_byte_start: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (ee_wr && !busy && !standby_q && !stop_in && enable_q && !arm_q)
        |=> busy && state_q == eepc_pkg::ST_BYTE) else $error("Enabled write did not start.");
    a_row_start: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (ctrl_wr && !busy && wdata_in[eepc_pkg::GO_BIT] && enable_q && arm_q && !standby_q
        && !stop_in) |=> busy && go_q && state_q == eepc_pkg::ST_ROW)
        else $error("Armed start did not begin a row.");
    a_row_load: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (arm_q && !go_q && ee_wr && ee_ok) |=> row_loaded[$past(addr_in[2:0])]
        && row_q == $past(addr_in[7:3])) else $error("Row byte not latched.");
    a_arm_clears: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        arm_set |=> row_loaded == 8'h00)
        else $error("Arming left latches loaded.");
    a_drop_row: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (ctrl_wr && !busy && !wdata_in[eepc_pkg::ARM_BIT]) |=> !arm_q && row_loaded == 8'h00)
        else $error("Dropped row still armed.");
    a_no_row_start: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (ctrl_wr && !busy && wdata_in[eepc_pkg::GO_BIT] && !(enable_q && arm_q))
        |=> !go_q && !busy) else $error("Start took effect unarmed.");
    a_stop_no_start: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (stop_in && !busy) |=> !busy)
        else $error("Cycle began on stop.");
    a_unloaded_kept: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (ev_done && state_q == eepc_pkg::ST_ROW && !row_loaded[1])
        |=> $stable(mem_q[{row_q[2:0], 3'h1}])) else $error("Unloaded row byte changed.");
endmodule : eepc_ctrl

// [core/eepc_row_latch.sv]
// Eight-byte volatile row latch with per-byte loaded flags.
`timescale 1ns/10ps
module eepc_row_latch #(
    parameter int BYTES = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic clear_in,
    input wire logic load_in,
    input wire logic [$clog2(BYTES)-1:0] sel_in,
    input wire logic [7:0] data_in,
    output logic [BYTES*8-1:0] data_out,
    output logic [BYTES-1:0] loaded_out
);
    initial begin
        if (BYTES != 8) $error("Row latch must hold eight bytes.");
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            loaded_out <= '0;
        end else if (clear_in) begin
            loaded_out <= '0;
        end else if (load_in) begin
            loaded_out[sel_in] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            data_out <= '0;
        end else if (clear_in) begin
            data_out <= '0;
        end else if (load_in) begin
            data_out[sel_in*8 +: 8] <= data_in;
        end
    end
endmodule : eepc_row_latch

// [shared/eepc_pkg.sv]
// Shared constants for the EEPROM programming controller.
package eepc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'hEA;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'hEB;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'hEC;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] EE_TOP_ADDR = 8'h3F;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int STANDBY_BIT = 6;
    localparam int GO_BIT = 3;
    localparam int ARM_BIT = 2;
    localparam int BUSY_BIT = 1;
    localparam int ENABLE_BIT = 0;
    // ------------------------------------------------------------
    // Interrupt status fields
    // ------------------------------------------------------------
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ABORT_BIT = 1;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int PROG_TIME_NS = 80;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {ST_IDLE, ST_BYTE, ST_ROW} eepc_state_t;
endpackage : eepc_pkg

// [sim/eepc_cpu_model.sv]
// Data-space bus master standing in for the CPU core.
`timescale 1ns/10ps
module eepc_cpu_model (
    input wire logic sys_clk_in,
    input wire logic [7:0] rdata_in,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // Released lines show the inverse so stale values cannot pass for fresh ones.
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge sys_clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask : write
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge sys_clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask : read
    task automatic wait_ready(output bit ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int i = 0; i < 64 && !ok; i++) begin
            read(eepc_pkg::CTRL_ADDR, s);
            ok = (s[eepc_pkg::BUSY_BIT] === 1'b0);
        end
    endtask : wait_ready
endmodule : eepc_cpu_model

// [sim/tb.sv]
// Self-checking bench for the EEPROM programming controller.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb;
    localparam int PC = 8;
    localparam logic [7:0] CT = eepc_pkg::CTRL_ADDR;
    localparam logic [7:0] ST = eepc_pkg::IRQ_STATUS_ADDR;
    localparam logic [7:0] MK = eepc_pkg::IRQ_MASK_ADDR;
    logic sys_clk_in, rst_b_in, stop, sel;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd, busy, standby, irq;
    bit ok;
    int err_count, n_checks, n;
    // Kind 0 writes, 1 reads and compares, 2 polls until idle.
    logic [17:0] rows [12] = '{
        {2'd1, CT, 8'h00},
        {2'd0, CT, 8'h45},
        {2'd1, CT, 8'h00},
        {2'd0, CT, 8'h01},
        {2'd0, 8'h05, 8'hA5},
        {2'd2, 16'h0000},
        {2'd1, 8'h05, 8'hA5},
        {2'd0, 8'h19, 8'h77},
        {2'd2, 16'h0000},
        {2'd0, CT, 8'h00},
        {2'd0, 8'h05, 8'h3C},
        {2'd1, 8'h05, 8'hA5}
    };
    eepc_ctrl #(.PROG_CYCLES(PC)) DUT (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .ee_sel_in(sel),
        .stop_in(stop), .rdata_out(rdata), .busy_out(busy), .standby_out(standby),
        .irq_out(irq));
    eepc_cpu_model cpu (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    task automatic finish_test;
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic poll;
        cpu.wait_ready(ok);
        if (!ok) begin
            err_count++;
            finish_test();
        end
    endtask : poll
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        cpu.read(a, d);
        `CHK("read", e, d)
    endtask : rd_chk
    // A fixed window longer than any cycle; counts every busy cycle in it.
    task automatic busy_len(input int e);
        n = 0;
        for (int i = 0; i < 64; i++) begin
            @(negedge sys_clk_in);
            if (busy === 1'b1) n++;
        end
        `CHK("busy cycles", e, n)
    endtask : busy_len
    initial begin
        sys_clk_in = 1'b0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        rst_b_in = 1'b0;
        stop = 1'b0;
        sel = 1'b1;
        repeat (12) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        foreach (rows[i]) begin
            case (rows[i][17:16])
                2'd0: cpu.write(rows[i][15:8], rows[i][7:0]);
                2'd1: rd_chk(rows[i][15:8], rows[i][7:0]);
                default: poll();
            endcase
        end
        cpu.write(CT, 8'h01);
        cpu.write(8'h08, 8'h81);
        busy_len(PC);
        cpu.write(MK, 8'h00);
        cpu.write(ST, 8'h03);
        cpu.write(8'h06, 8'h66);
        rd_chk(CT, 8'h02);
        cpu.write(CT, 8'h41);
        cpu.write(8'h07, 8'h12);
        poll();
        `CHK("standby", 1'b0, standby)
        rd_chk(ST, 8'h03);
        rd_chk(8'h06, 8'h66);
        `CHK("irq masked", 1'b0, irq)
        cpu.write(MK, 8'h02);
        rd_chk(MK, 8'h02);
        `CHK("irq", 1'b1, irq)
        cpu.write(ST, 8'h02);
        rd_chk(ST, 8'h01);
        `CHK("irq cleared", 1'b0, irq)
        cpu.write(CT, 8'h05);
        cpu.write(8'h18, 8'h11);
        cpu.write(8'h1A, 8'h22);
        cpu.write(8'h1B, 8'h33);
        cpu.write(CT, 8'h0D);
        busy_len(PC);
        rd_chk(8'h18, 8'h11);
        rd_chk(8'h1A, 8'h22);
        rd_chk(8'h1B, 8'h33);
        rd_chk(8'h19, 8'h77);
        cpu.write(8'h1C, 8'h44);
        busy_len(PC);
        cpu.write(CT, 8'h04);
        cpu.write(8'h1A, 8'h55);
        cpu.write(CT, 8'h0C);
        busy_len(0);
        cpu.write(CT, 8'h05);
        cpu.write(8'h1A, 8'h55);
        cpu.write(CT, 8'h01);
        cpu.write(CT, 8'h05);
        cpu.write(8'h18, 8'h44);
        cpu.write(CT, 8'h0D);
        busy_len(PC);
        rd_chk(8'h18, 8'h44);
        rd_chk(8'h1A, 8'h22);
        @(posedge sys_clk_in);
        sel <= 1'b0;
        cpu.write(8'h05, 8'h00);
        busy_len(0);
        @(posedge sys_clk_in);
        sel <= 1'b1;
        rd_chk(8'h05, 8'hA5);
        cpu.write(CT, 8'h41);
        @(negedge sys_clk_in);
        `CHK("standby on", 1'b1, standby)
        cpu.write(8'h05, 8'h00);
        busy_len(0);
        cpu.write(CT, 8'h01);
        @(negedge sys_clk_in);
        `CHK("standby off", 1'b0, standby)
        @(posedge sys_clk_in);
        stop <= 1'b1;
        @(posedge sys_clk_in);
        stop <= 1'b0;
        cpu.write(8'h05, 8'h00);
        `CHK("stop standby", 1'b1, standby)
        busy_len(0);
        @(posedge sys_clk_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        `CHK("reset standby", 1'b0, standby)
        rst_b_in <= 1'b1;
        rd_chk(CT, 8'h00);
        finish_test();
    end
endmodule : tb
